//--- rtl/pin_mux_pkg.sv
package pin_mux_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] timer_mode_index = 8'hee;
  localparam logic [7:0] analog_index = 8'hef;
  localparam logic [7:0] port1_mode_index = 8'heb;
  localparam logic [7:0] status_index = 8'hf8;
  localparam int addr_width = 12;
  localparam logic [11:0] timer_mode_addr = {2'b00, timer_mode_index, 2'b00};
  localparam logic [11:0] analog_addr = {2'b00, analog_index, 2'b00};
  localparam logic [11:0] port1_mode_addr = {2'b00, port1_mode_index, 2'b00};
  localparam logic [11:0] status_addr = {2'b00, status_index, 2'b00};
  // timer_pin_output_mode fields
  localparam int timer_out_select_bit = 7;
  localparam int timer_out_enable_bit = 6;
  localparam int fixed_rate_select_bit = 5;
  localparam int variable_rate_select_bit = 4;
  localparam logic [3:0] timer_mode_reset = 4'h0;
  localparam logic [3:0] timer_mode_unused = 4'hf;
  // port1_mode_register field
  localparam int irq5_pin_select_bit = 5;
  localparam logic [7:0] port1_mode_reset = 8'h00;
  localparam logic [7:0] analog_reset = 8'h00;
  // fixed rates: clock/2048 and clock/1024
  localparam int slow_divide = 2048;
  localparam int fast_divide = 1024;
  localparam int div_width = $clog2(slow_divide);
  localparam int slow_tap = $clog2(slow_divide) - 1;
  localparam int fast_tap = $clog2(fast_divide) - 1;

  typedef enum logic [2:0] {
    mode_gpio,
    mode_low,
    mode_fixed,
    mode_variable,
    mode_irq
  } pin_mode_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [addr_width-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_request_type;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_answer_type;
endpackage : pin_mux_pkg

//--- rtl/port_mode_pin_function_select.sv
`timescale 1ns/1ps
// How it works
// - interrupt select 1 makes pin an interrupt input; all selects 0 give plain I/O
// - timer output selected but not enabled drives the pin constantly low
// - fixed wave is clock/2048 with rate bit 0, clock/1024 with it 1
// - variable mode inverts the pin on each timer overflow, rate bit ignored
// - timer mode register: upper four bits reset 0 and read/write, lower read 1
// - eight write-only analog selects, 1 analog, 0 digital, all reset 0
module port_mode_pin_function_select
  import pin_mux_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire apb_request_type apb_req,
  output apb_answer_type apb_ans,
  input wire logic timer_overflow,
  input wire logic gpio_data,
  input wire logic gpio_dir,
  input wire logic port1_bit5_in,
  output logic port1_bit5_out,
  output logic port1_bit5_oe,
  output logic port1_bit5_data,
  output logic irq5_level,
  output logic [7:0] analog_channel_select
);

  logic [3:0] timer_mode;
  logic [7:0] port1_mode;
  logic [div_width-1:0] div_cnt;
  logic toggle;
  logic pin_sync1;
  logic pin_sync2;
  pin_mode_type mode;

  wire logic setup = apb_req.psel && !apb_req.penable;
  wire logic access = apb_req.psel && apb_req.penable && apb_ans.pready;
  wire logic lane0 = apb_req.pwrite && apb_req.pstrb[0];
  wire logic hit_timer = apb_req.paddr == timer_mode_addr;
  wire logic hit_analog = apb_req.paddr == analog_addr;
  wire logic hit_port1 = apb_req.paddr == port1_mode_addr;
  wire logic hit_status = apb_req.paddr == status_addr;
  wire logic hit_any = hit_timer || hit_analog || hit_port1 || hit_status;
  wire logic wr_timer = access && lane0 && hit_timer;
  wire logic wr_analog = access && lane0 && hit_analog;
  wire logic wr_port1 = access && lane0 && hit_port1;

  wire logic irq5_sel = port1_mode[irq5_pin_select_bit];
  wire logic out_sel = timer_mode[timer_out_select_bit - 4];
  wire logic out_en = timer_mode[timer_out_enable_bit - 4];
  wire logic fast = timer_mode[fixed_rate_select_bit - 4];
  wire logic var_rate = timer_mode[variable_rate_select_bit - 4];

  // interrupt select outranks every timer bit
  wire pin_mode_type next_mode =
    irq5_sel ? mode_irq :
    !out_sel ? mode_gpio :
    !out_en ? mode_low :
    var_rate ? mode_variable : mode_fixed;

  wire logic wave = fast ? div_cnt[fast_tap] : div_cnt[slow_tap];

  logic next_out;
  logic next_oe;
  always_comb begin
    next_out = 1'b0;
    next_oe = 1'b0;
    case (next_mode)
      mode_gpio: begin
        next_out = gpio_data;
        next_oe = gpio_dir;
      end
      mode_low: begin
        next_out = 1'b0;
        next_oe = 1'b1;
      end
      mode_fixed: begin
        next_out = wave;
        next_oe = 1'b1;
      end
      mode_variable: begin
        next_out = toggle;
        next_oe = 1'b1;
      end
      mode_irq: begin
        next_out = 1'b0;
        next_oe = 1'b0;
      end
      default: begin
        next_out = 1'b0;
        next_oe = 1'b0;
      end
    endcase
  end

  wire logic [7:0] status_word = {3'b000, port1_bit5_out, port1_bit5_oe, mode};
  wire logic [7:0] read_byte =
    hit_timer ? {timer_mode, timer_mode_unused} :
    hit_port1 ? port1_mode :
    hit_status ? status_word : 8'h00;

  // bus answer is prepared in setup, so every access has no wait state
  always_ff @(posedge clock) begin
    if (srst) begin
      apb_ans <= '0;
    end else begin
      apb_ans.pready <= setup;
      apb_ans.pslverr <= setup && !hit_any;
      apb_ans.prdata <= setup ? {24'h00_0000, read_byte} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      timer_mode <= timer_mode_reset;
    end else if (wr_timer) begin
      timer_mode <= apb_req.pwdata[7:4];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      analog_channel_select <= analog_reset;
    end else if (wr_analog) begin
      analog_channel_select <= apb_req.pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      port1_mode <= port1_mode_reset;
    end else if (wr_port1) begin
      port1_mode <= apb_req.pwdata[7:0];
    end
  end

  // free running, never reloaded, so both rates stay at half duty
  always_ff @(posedge clock) begin
    if (srst) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // restarts low whenever variable mode is left
  always_ff @(posedge clock) begin
    if (srst) begin
      toggle <= 1'b0;
    end else if (next_mode != mode_variable) begin
      toggle <= 1'b0;
    end else if (timer_overflow) begin
      toggle <= !toggle;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pin_sync1 <= 1'b0;
      pin_sync2 <= 1'b0;
    end else begin
      pin_sync1 <= port1_bit5_in;
      pin_sync2 <= pin_sync1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      mode <= mode_gpio;
      port1_bit5_out <= 1'b0;
      port1_bit5_oe <= 1'b0;
      port1_bit5_data <= 1'b0;
      irq5_level <= 1'b1;
    end else begin
      mode <= next_mode;
      port1_bit5_out <= next_out;
      port1_bit5_oe <= next_oe;
      port1_bit5_data <= pin_sync2;
      // idle high keeps a deselected interrupt quiet
      irq5_level <= (next_mode == mode_irq) ? pin_sync2 : 1'b1;
    end
  end

  // attempts at the edge that leaves reset would see reset values, so skip it
  logic last_srst;
  always_ff @(posedge clock) begin
    last_srst <= srst;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst || last_srst);

  property p_irq_wins;
    irq5_sel |=> !port1_bit5_oe && mode == mode_irq;
  endproperty
  a_irq_wins: assert property (p_irq_wins) else $error("irq pin driven");

  property p_gpio;
    !irq5_sel && !out_sel |=> port1_bit5_oe == $past(gpio_dir)
      && port1_bit5_out == $past(gpio_data);
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio path wrong");

  property p_low;
    !irq5_sel && out_sel && !out_en |=> port1_bit5_oe && !port1_bit5_out;
  endproperty
  a_low: assert property (p_low) else $error("pin not held low");

  sequence s_slow_edge;
    next_mode == mode_fixed && !fast && div_cnt == 11'h3ff ##1
      next_mode == mode_fixed && !fast;
  endsequence
  property p_slow;
    s_slow_edge |=> port1_bit5_out;
  endproperty
  a_slow: assert property (p_slow) else $error("slow wave wrong");

  sequence s_fast_fall;
    next_mode == mode_fixed && fast && div_cnt == 11'h3ff ##1
      next_mode == mode_fixed && fast;
  endsequence
  property p_fast;
    s_fast_fall |=> !port1_bit5_out;
  endproperty
  a_fast: assert property (p_fast) else $error("fast wave wrong");

  sequence s_overflow;
    next_mode == mode_variable && timer_overflow ##1 next_mode == mode_variable;
  endsequence
  property p_toggle;
    s_overflow |=> port1_bit5_out != $past(port1_bit5_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");

  property p_low_nibble;
    setup && hit_timer |=> apb_ans.prdata[3:0] == 4'hf && apb_ans.pready;
  endproperty
  a_low_nibble: assert property (p_low_nibble) else $error("low bits not 1");

  property p_analog;
    wr_analog |=> analog_channel_select == $past(apb_req.pwdata[7:0]);
  endproperty
  a_analog: assert property (p_analog) else $error("analog not stored");

  property p_wrap;
    div_cnt == 11'h7ff |=> div_cnt == 11'h000 ##1 div_cnt == 11'h001;
  endproperty
  a_wrap: assert property (p_wrap) else $error("divider not free");

  property p_irq_level;
    irq5_sel |=> irq5_level == $past(pin_sync2);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level lost");

  property p_irq_idle;
    !irq5_sel |=> irq5_level;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("idle irq level low");

  property p_timer_drive;
    next_mode == mode_fixed || next_mode == mode_variable |=> port1_bit5_oe;
  endproperty
  a_timer_drive: assert property (p_timer_drive) else $error("wave not driven");

  sequence s_var_enter;
    next_mode != mode_variable ##1 next_mode == mode_variable;
  endsequence
  property p_var_start;
    s_var_enter |=> !port1_bit5_out;
  endproperty
  a_var_start: assert property (p_var_start) else $error("toggle not low on entry");

  sequence s_var_quiet;
    next_mode == mode_variable && !timer_overflow ##1
      next_mode == mode_variable && !timer_overflow;
  endsequence
  property p_var_quiet;
    s_var_quiet |=> $stable(port1_bit5_out);
  endproperty
  a_var_quiet: assert property (p_var_quiet) else $error("toggle without overflow");

  property p_timer_store;
    wr_timer |=> timer_mode == $past(apb_req.pwdata[7:4]);
  endproperty
  a_timer_store: assert property (p_timer_store) else $error("timer mode not stored");

  property p_timer_read;
    setup && hit_timer |=> apb_ans.prdata[7:4] == $past(timer_mode);
  endproperty
  a_timer_read: assert property (p_timer_read) else $error("timer mode read wrong");

  property p_ready_one;
    setup |=> apb_ans.pready ##1 !apb_ans.pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready not one cycle");

  property p_analog_read;
    setup && hit_analog |=> apb_ans.prdata == 32'h0000_0000 && apb_ans.pready;
  endproperty
  a_analog_read: assert property (p_analog_read) else $error("analog select readable");

  property p_analog_hold;
    !wr_analog |=> $stable(analog_channel_select);
  endproperty
  a_analog_hold: assert property (p_analog_hold) else $error("analog changed unasked");

  property p_half_duty;
    $changed(div_cnt[slow_tap]) |-> div_cnt[slow_tap-1:0] == '0;
  endproperty
  a_half_duty: assert property (p_half_duty) else $error("slow tap off phase");

endmodule : port_mode_pin_function_select

//--- sim/pin_partner.sv
`timescale 1ns/1ps
module pin_partner (
  input wire logic clock,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic ext_drive,
  input wire logic ext_level,
  output logic pad
);
  logic filler = 1'b0;
  // no pull on this pad: an undriven pin shows a changing level, never a stale one
  always @(posedge clock) filler <= ~filler;
  assign pad = pin_oe ? pin_out : (ext_drive ? ext_level : filler);
endmodule : pin_partner

//--- sim/tb_port_mode_pin_function_select.sv
`timescale 1ns/1ps
module tb_port_mode_pin_function_select;
  import pin_mux_pkg::*;
  typedef struct packed {logic [7:0] p1; logic [7:0] tm; logic [2:0] mode;} row_type;
  logic clock = 1'b0;
  logic srst = 1'b1;
  apb_request_type req = '0;
  apb_answer_type ans;
  logic ovf = 1'b0, gdata = 1'b1, gdir = 1'b1, ext_drive = 1'b0, ext_level = 1'b1;
  logic pad, pin_out, pin_oe, pin_data, irq_lvl, err;
  logic [7:0] analog;
  logic [31:0] rd;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  row_type rows [9] = '{'{8'h00, 8'h00, 3'd0}, '{8'hdf, 8'h00, 3'd0}, '{8'h00, 8'h80, 3'd1},
    '{8'h00, 8'hb0, 3'd1}, '{8'h00, 8'hc0, 3'd2}, '{8'h00, 8'he0, 3'd2},
    '{8'h00, 8'hd0, 3'd3}, '{8'h00, 8'hf0, 3'd3}, '{8'h20, 8'hf0, 3'd4}};
  always #12.5 clock = ~clock;
  port_mode_pin_function_select uut (.clock(clock), .srst(srst), .apb_req(req), .apb_ans(ans),
    .timer_overflow(ovf), .gpio_data(gdata), .gpio_dir(gdir), .port1_bit5_in(pad),
    .port1_bit5_out(pin_out), .port1_bit5_oe(pin_oe), .port1_bit5_data(pin_data),
    .irq5_level(irq_lvl), .analog_channel_select(analog));
  pin_partner far (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .ext_drive(ext_drive),
    .ext_level(ext_level), .pad(pad));
  task complete_run;
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task xfer(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge clock);
    req <= '{1'b1, 1'b0, wr, a, {24'h00_0000, d}, s};
    @(posedge clock);
    req.penable <= 1'b1;
    do @(posedge clock); while (ans.pready !== 1'b1);
    rd = ans.prdata;
    err = ans.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer
  // overflow held n cycles; two in a row must toggle twice
  task pulses(input int n);
    @(posedge clock) ovf <= 1'b1;
    repeat (n) @(posedge clock);
    ovf <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : pulses
  task half(input int exp);
    logic v;
    int n;
    // first two changes may come from the mode switch, not a full half period
    for (int k = 0; k < 4; k++) begin
      v = pin_out;
      n = 0;
      while (pin_out === v && n < 3000) begin
        @(posedge clock);
        n++;
      end
      if (k > 1) chk("half_period", exp, n);
    end
  endtask : half
  initial begin
    repeat (2) @(posedge clock);
    chk("reset_analog", 8'h00, analog);
    chk("reset_irq", 1'b1, irq_lvl);
    srst <= 1'b0;
    foreach (rows[i]) begin
      xfer(1'b1, port1_mode_addr, rows[i].p1, 4'hf);
      xfer(1'b1, timer_mode_addr, rows[i].tm, 4'hf);
      xfer(1'b0, timer_mode_addr, 8'h00, 4'hf);
      chk("timer_reg", {24'h00_0000, rows[i].tm[7:4], 4'hf}, rd);
      xfer(1'b0, status_addr, 8'h00, 4'hf);
      chk("mode", rows[i].mode, rd[2:0]);
      chk("oe", rows[i].mode != 3'd4, pin_oe);
      if (rows[i].mode < 3'd2) chk("out", rows[i].mode == 3'd0, pin_out);
    end
    ext_drive <= 1'b1;
    ext_level <= 1'b0;
    repeat (6) @(posedge clock);
    chk("irq_level", 1'b0, irq_lvl);
    chk("irq_pin_data", 1'b0, pin_data);
    xfer(1'b1, port1_mode_addr, 8'h00, 4'hf);
    ext_drive <= 1'b0;
    xfer(1'b1, timer_mode_addr, 8'he0, 4'hf);
    half(512);
    xfer(1'b1, timer_mode_addr, 8'hc0, 4'hf);
    half(1024);
    xfer(1'b1, timer_mode_addr, 8'hd0, 4'hf);
    repeat (3) @(posedge clock);
    chk("var_start", 1'b0, pin_out);
    pulses(1);
    chk("var_toggle", 1'b1, pin_out);
    pulses(2);
    chk("var_double", 1'b1, pin_out);
    xfer(1'b1, timer_mode_addr, 8'h80, 4'hf);
    pulses(1);
    chk("low_ignores", 1'b0, pin_out);
    xfer(1'b1, analog_addr, 8'ha5, 4'hf);
    xfer(1'b1, analog_addr, 8'h00, 4'h0);
    xfer(1'b0, analog_addr, 8'h00, 4'hf);
    chk("analog_read", 32'h0000_0000, rd);
    chk("analog_sel", 8'ha5, analog);
    xfer(1'b0, 12'h004, 8'h00, 4'hf);
    chk("unmapped_err", 1'b1, err);
    xfer(1'b1, timer_mode_addr, 8'h00, 4'hf);
    gdata <= 1'b0;
    gdir <= 1'b0;
    ext_drive <= 1'b1;
    ext_level <= 1'b0;
    repeat (4) @(posedge clock);
    chk("gpio_oe", 1'b0, pin_oe);
    chk("gpio_out", 1'b0, pin_out);
    chk("irq_idle", 1'b1, irq_lvl);
    chk("pin_data", 1'b0, pin_data);
    @(posedge clock) srst <= 1'b1;
    @(posedge clock) srst <= 1'b0;
    @(posedge clock);
    chk("rereset_analog", 8'h00, analog);
    xfer(1'b0, timer_mode_addr, 8'h00, 4'hf);
    chk("rereset_timer", 32'h0000_000f, rd);
    complete_run();
  end
endmodule : tb_port_mode_pin_function_select
